// >>> common/phy_vendor_cfg.svh
// Offsets, field positions, reset values and timing counts
`ifndef PHY_VENDOR_CFG_SVH
`define PHY_VENDOR_CFG_SVH

// Management register numbers
`define CFG_REG_ADDR     5'h10
`define STS_REG_ADDR     5'h11

// Configuration word fields
`define CFG_ENC_BIT      15
`define CFG_SCR_BIT      14
`define CFG_ALIGN_BIT    13
`define CFG_ADPOK_BIT    12
`define CFG_TX_BIT       10
`define CFG_FLINK_BIT    7
`define CFG_RPD_BIT      4
`define CFG_STATE_MACHINE_RESET_BIT    3
`define CFG_MFPS_BIT     2
`define CFG_SLEEP_BIT    1
`define CFG_REMOTE_LOOPOUT_BIT    0

// Status word fields
`define STS_RES_HI       15
`define STS_RES_LO       12
`define STS_ADR_HI       8
`define STS_ADR_LO       4
`define STS_MON_HI       3

// Reset values
`define RST_RPD          1'b1
`define RST_RESULT       4'hF
`define RST_ADDR         5'h00
`define RST_WORD         16'h0000

// Timing: state machine reset pulse, ns and cycles at 25 MHz
`define STATE_MACHINE_RESET_TIME_NS    320
`define CLK_PERIOD_NS    40
`define STATE_MACHINE_RESET_CYCLES     ((`STATE_MACHINE_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE     3'h4

`endif

// >>> common/phy_vendor_pkg.sv
// Types shared by the vendor configuration and status register block
package phy_vendor_pkg;

	// Negotiation monitor codes
	typedef enum logic [3:0] {
		MON_IDLE       = 4'b0000,
		MON_ABIL_MATCH = 4'b0001,
		MON_ACK_MATCH  = 4'b0010,
		MON_ACK_FAIL   = 4'b0011,
		MON_CONS_MATCH = 4'b0100,
		MON_CONS_FAIL  = 4'b0101,
		MON_PD_READY   = 4'b0110,
		MON_PD_FAIL    = 4'b0111,
		MON_DONE       = 4'b1000
	} neg_monitor_e;

	// State machine reset sequencer states
	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_HOLD = 1'b1
	} seq_state_e;

endpackage

// >>> src/pin_sync.sv
// Three-flop synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 5
) (
	input  wire logic             i_clock,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_pin,
	output logic      [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] meta_q;   // First stage, read only by stage two
	logic [WIDTH-1:0] s2_q;     // Second stage
	logic [WIDTH-1:0] s3_q;     // Third stage
	logic [WIDTH-1:0] level_q;  // Accepted level
	wire              agree;    // Stages two and three match

	assign agree   = (s2_q == s3_q);
	assign o_level = level_q;

	// Shift chain
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
		end else begin
			meta_q <= i_pin;
			s2_q   <= meta_q;
			s3_q   <= s2_q;
		end
	end

	// Accept only a settled value
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			level_q <= '0;
		end else if (agree) begin
			level_q <= s3_q;
		end
	end
endmodule // pin_sync

// >>> src/sm_reset_seq.sv
// Timed reset pulse for the PHY state machines
`timescale 1ns/1ps
`include "phy_vendor_cfg.svh"
module sm_reset_seq
	import phy_vendor_pkg::*;
#(
	parameter int CYCLES = `STATE_MACHINE_RESET_CYCLES
) (
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	input  wire logic i_start,
	output logic      o_busy
);
	seq_state_e state_q;  // Sequencer state
	seq_state_e state_d;
	logic [7:0] cnt_q;    // Cycles left in pulse
	logic [7:0] cnt_d;
	wire        last;     // Final cycle of pulse

	assign last   = (cnt_q == 8'h01);
	assign o_busy = (state_q == SEQ_HOLD);

	// Next state
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			SEQ_IDLE: begin
				if (i_start) begin
					state_d = SEQ_HOLD;
					cnt_d   = 8'(CYCLES);
				end
			end
			SEQ_HOLD: begin
				// Restart keeps the pulse going
				if (i_start) begin
					cnt_d = 8'(CYCLES);
				end else if (last) begin
					state_d = SEQ_IDLE;
					cnt_d   = 8'h00;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q <= SEQ_IDLE;
			cnt_q   <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end
endmodule // sm_reset_seq

// >>> src/phy_vendor_regs.sv
// Vendor configuration and status registers of the 10/100 PHY
`timescale 1ns/1ps
`include "phy_vendor_cfg.svh"
// Summary of operation
// - Encoding bypass skips 4B5B both ways
// - Scrambler bypass skips scramble and descramble
// - Alignment bypass skips receive and transmit coding
// - 100BASE-TX status bit always reads one
// - Forced link reports good 100M link
// - Auto reduced power enable resets to one
// - State machine reset self-clears when done
// - Preamble suppression resets off, one enables
// - Sleep powers down all but clocks
// - Wake restores configuration, resets state machines
// - Remote loopout returns receive data to transmit
// - Negotiation result bits load, reset to ones
// - Result bits meaningless outside negotiation mode
// - Station address from strap, read-write
// - Monitor code resets idle, tracks negotiation
// - Further monitor codes through completion
// - Reserved bits read zero, ignore writes
module phy_vendor_regs
	import phy_vendor_pkg::*;
#(
	parameter int STATE_MACHINE_RESET_LEN = `STATE_MACHINE_RESET_CYCLES
) (
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	// Management register access
	input  wire logic [4:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [15:0] i_reg_wdata,
	output logic      [15:0] o_reg_rdata,
	// Strap pins
	input  wire logic [4:0]  i_strap_addr,
	// Negotiation engine, same clock
	input  wire logic        i_an_mode,
	input  wire logic        i_an_done,
	input  wire logic [3:0]  i_an_result,
	input  wire logic [3:0]  i_an_monitor,
	// Datapath controls
	output logic             o_encoding_bypass,
	output logic             o_scrambler_bypass,
	output logic             o_alignment_bypass,
	output logic             o_adaptation_ok_bypass,
	output logic             o_force_link_100,
	output logic             o_auto_reduced_power_enable,
	output logic             o_state_machine_reset,
	output logic             o_preamble_suppress_control,
	output logic             o_sleep,
	output logic             o_remote_loopout,
	output logic             o_result_valid
);

	// Configuration bits
	logic       enc_q;        // Encoding bypass
	logic       scr_q;        // Scrambler bypass
	logic       align_q;      // Alignment bypass
	logic       adpok_q;      // Adaptation ok bypass
	logic       flink_q;      // Forced 100M link
	logic       rpd_q;        // Auto reduced power
	logic       mfps_q;       // Preamble suppression
	logic       sleep_q;      // Sleep request
	logic       remote_loopout_q;      // Remote loopout
	// Status fields
	logic [3:0] result_q;     // Resolved speed and duplex
	logic [4:0] addr_q;       // Station address
	neg_monitor_e mon_q;      // Negotiation monitor
	logic       an_mode_q;    // Negotiation mode seen
	// Strap capture
	logic [2:0] settle_q;     // Cycles since reset release, covers synchroniser fill
	logic       strap_done_q; // Address already loaded
	logic [15:0] rdata_q;     // Read data holding
	logic       busy;         // Sequencer pulse

	// Strap passes through synchroniser
	wire  [4:0] strap_lvl;

	// Decoded accesses
	wire        hit_cfg;      // Address is configuration word
	wire        hit_sts;      // Address is status word
	wire        wr_cfg;       // Write to configuration
	wire        wr_sts;       // Write to status
	wire        state_machine_reset_req;    // Management asked for reset
	wire        wake;         // Sleep bit falls
	wire        seq_start;    // Start reset sequencer
	wire [15:0] cfg_word;     // Configuration read view
	wire [15:0] sts_word;     // Status read view
	wire [15:0] rd_mux;       // Selected read data
	wire        strap_load;   // Load address from strap
	neg_monitor_e mon_next;   // Legalised monitor code

	// Map unknown monitor values to idle
	function automatic neg_monitor_e legal_mon(input logic [3:0] code);
		neg_monitor_e r;
		r = MON_IDLE;
		if (code <= 4'h8) begin
			r = neg_monitor_e'(code);
		end
		return r;
	endfunction

	// Address compare shared by read and write paths
	function automatic logic addr_is(input logic [4:0] a, input logic [4:0] b);
		return (a == b);
	endfunction

	// Access decode
	assign hit_cfg   = addr_is(i_reg_addr, `CFG_REG_ADDR);
	assign hit_sts   = addr_is(i_reg_addr, `STS_REG_ADDR);
	assign wr_cfg    = i_reg_wr && hit_cfg;
	assign wr_sts    = i_reg_wr && hit_sts;
	// Only a written one to the reset bit makes a management reset request
	assign state_machine_reset_req = wr_cfg && i_reg_wdata[`CFG_STATE_MACHINE_RESET_BIT];
	// Leaving sleep also resets the state machines
	assign wake      = wr_cfg && sleep_q && !i_reg_wdata[`CFG_SLEEP_BIT];
	assign seq_start = state_machine_reset_req || wake;
	assign mon_next  = legal_mon(i_an_monitor);

	// Configuration read view; reserved read zero, TX reads one
	assign cfg_word = {enc_q, scr_q, align_q, adpok_q, 1'b0, 1'b1,
		2'b00, flink_q, 2'b00, rpd_q, busy, mfps_q, sleep_q, remote_loopout_q};
	// Status read view; bits 11..9 reserved
	assign sts_word = {result_q, 3'b000, addr_q, mon_q};

	// Read select; unmapped numbers read zero
	assign rd_mux = hit_cfg ? cfg_word : (hit_sts ? sts_word : `RST_WORD);

	// Strap address is taken once the synchroniser has filled
	assign strap_load = !strap_done_q && (settle_q == `STRAP_SETTLE);

	// Strap pin synchroniser
	pin_sync #(
		.WIDTH (5)
	) u_strap_sync (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_pin     (i_strap_addr),
		.o_level   (strap_lvl)
	);

	// Timed state machine reset pulse
	sm_reset_seq #(
		.CYCLES (STATE_MACHINE_RESET_LEN)
	) u_sm_reset (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_start   (seq_start),
		.o_busy    (busy)
	);

	// Writable configuration bits
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			enc_q   <= 1'b0;
			scr_q   <= 1'b0;
			align_q <= 1'b0;
			adpok_q <= 1'b0;
			flink_q <= 1'b0;
			rpd_q   <= `RST_RPD;
			mfps_q  <= 1'b0;
			sleep_q <= 1'b0;
			remote_loopout_q <= 1'b0;
		end else if (wr_cfg) begin
			// Bits 11..8, 6, 5 and 3 are not stored
			enc_q   <= i_reg_wdata[`CFG_ENC_BIT];
			scr_q   <= i_reg_wdata[`CFG_SCR_BIT];
			align_q <= i_reg_wdata[`CFG_ALIGN_BIT];
			adpok_q <= i_reg_wdata[`CFG_ADPOK_BIT];
			flink_q <= i_reg_wdata[`CFG_FLINK_BIT];
			rpd_q   <= i_reg_wdata[`CFG_RPD_BIT];
			mfps_q  <= i_reg_wdata[`CFG_MFPS_BIT];
			sleep_q <= i_reg_wdata[`CFG_SLEEP_BIT];
			remote_loopout_q <= i_reg_wdata[`CFG_REMOTE_LOOPOUT_BIT];
		end
	end

	// Datapath controls; held through sleep so wake restores them
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_encoding_bypass           <= 1'b0;
			o_scrambler_bypass          <= 1'b0;
			o_alignment_bypass          <= 1'b0;
			o_adaptation_ok_bypass      <= 1'b0;
			o_force_link_100            <= 1'b0;
			o_auto_reduced_power_enable <= `RST_RPD;
			o_state_machine_reset       <= 1'b0;
			o_preamble_suppress_control <= 1'b0;
			o_sleep                     <= 1'b0;
			o_remote_loopout            <= 1'b0;
		end else begin
			o_encoding_bypass           <= enc_q;
			o_scrambler_bypass          <= scr_q;
			o_alignment_bypass          <= align_q;
			o_adaptation_ok_bypass      <= adpok_q;
			o_force_link_100            <= flink_q;
			o_auto_reduced_power_enable <= rpd_q;
			o_state_machine_reset       <= busy;
			o_preamble_suppress_control <= mfps_q;
			o_sleep                     <= sleep_q;
			o_remote_loopout            <= remote_loopout_q;
		end
	end

	// Negotiation result and monitor, hardware owned
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			result_q  <= `RST_RESULT;
			mon_q     <= MON_IDLE;
			an_mode_q <= 1'b0;
		end else begin
			// Status writes never reach these fields
			if (i_an_done) begin
				result_q <= i_an_result;
			end
			mon_q     <= mon_next;
			an_mode_q <= i_an_mode;
		end
	end

	// Result flagged usable only in negotiation mode
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_result_valid <= 1'b0;
		end else begin
			o_result_valid <= an_mode_q && (mon_q == MON_DONE);
		end
	end

	// Reset release counter for strap capture
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			settle_q <= 3'h0;
		end else if (settle_q != `STRAP_SETTLE) begin
			settle_q <= settle_q + 3'h1;
		end
	end

	// Station address: strap once, then management writes
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			addr_q       <= `RST_ADDR;
			strap_done_q <= 1'b0;
		end else if (wr_sts) begin
			addr_q       <= i_reg_wdata[`STS_ADR_HI:`STS_ADR_LO];
			strap_done_q <= 1'b1;
		end else if (strap_load) begin
			addr_q       <= strap_lvl;
			strap_done_q <= 1'b1;
		end
	end

	// Registered read data
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_q <= `RST_WORD;
		end else if (i_reg_rd) begin
			rdata_q <= rd_mux;
		end
	end

	assign o_reg_rdata = rdata_q;

	// Checks on the design's own behaviour
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);

	// Reset pulse starts then ends by itself
	a_state_machine_reset_self_clear: assert property (
		state_machine_reset_req |=> busy ##[1:300] !busy)
		else $error("state machine reset did not self clear");

	// Busy cycles since the last start, for the length check
	logic [7:0] busy_run_q;
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			busy_run_q <= 8'h00;
		end else if (seq_start) begin
			busy_run_q <= 8'h00;
		end else if (busy) begin
			busy_run_q <= busy_run_q + 8'h01;
		end
	end

	// Pulse lasts the full count
	a_state_machine_reset_length: assert property (
		$fell(busy) |-> busy_run_q == 8'(STATE_MACHINE_RESET_LEN))
		else $error("state machine reset pulse length wrong");

	// Waking from sleep resets state machines
	a_wake_reset: assert property (
		wake |=> busy ##1 o_state_machine_reset)
		else $error("wake did not reset state machines");

	// TX status always one on read
	a_tx_reads_one: assert property (
		i_reg_rd && hit_cfg |=> o_reg_rdata[`CFG_TX_BIT])
		else $error("100BASE-TX bit read zero");

	// Reserved bits read zero
	a_reserved_zero: assert property (
		i_reg_rd && hit_sts |=> o_reg_rdata[11:9] == 3'b000)
		else $error("reserved status bits not zero");

	// Result loads from negotiation engine
	a_result_load: assert property (
		i_an_done |=> result_q == $past(i_an_result))
		else $error("negotiation result not loaded");

	// Management write leaves result untouched
	a_ro_write: assert property (
		wr_sts && !i_an_done |=> $stable(result_q))
		else $error("write changed read-only result");

	// Monitor follows engine one cycle on
	a_monitor_track: assert property (
		i_an_monitor == 4'h1 |=> mon_q == MON_ABIL_MATCH)
		else $error("monitor code not tracked");

	// Encoding bypass reaches the datapath
	a_enc_bypass: assert property (
		wr_cfg |=> ##1 o_encoding_bypass == $past(i_reg_wdata[15], 2))
		else $error("encoding bypass not applied");

	// Sleep output follows written bit
	a_sleep_apply: assert property (
		wr_cfg && i_reg_wdata[1] |=> ##1 o_sleep)
		else $error("sleep not entered");

	// Strap value lands in the address field
	a_strap_capture: assert property (
		strap_load && !wr_sts |=> addr_q == $past(strap_lvl))
		else $error("strap address not captured");

	// Unmapped register numbers read zero
	a_unmapped_zero: assert property (
		i_reg_rd && !hit_cfg && !hit_sts |=> o_reg_rdata == 16'h0000)
		else $error("unmapped register read not zero");

	// Result never flagged usable outside negotiation mode
	a_result_mode: assert property (
		!an_mode_q |=> !o_result_valid)
		else $error("result flagged valid outside negotiation");

	// Codes beyond completion show idle
	a_monitor_legal: assert property (
		i_an_monitor > 4'h8 |=> mon_q == MON_IDLE)
		else $error("illegal monitor code shown");

endmodule // phy_vendor_regs

// >>> dv/mgmt_station.sv
// Management station model driving the register strobe port
`timescale 1ns/1ps
module mgmt_station (
	input  wire logic        i_clock,
	input  wire logic [15:0] i_reg_rdata,
	output logic      [4:0]  o_reg_addr,
	output logic             o_reg_wr,
	output logic             o_reg_rd,
	output logic      [15:0] o_reg_wdata
);
	// Idle bus at time zero
	initial begin
		o_reg_addr  = 5'h00;
		o_reg_wr    = 1'b0;
		o_reg_rd    = 1'b0;
		o_reg_wdata = 16'h0000;
	end

	// One write pulse; the bus is scrambled once released
	task automatic wr(input logic [4:0] addr, input logic [15:0] data);
		@(negedge i_clock);
		o_reg_addr  = addr;
		o_reg_wdata = data;
		o_reg_wr    = 1'b1;
		@(negedge i_clock);
		o_reg_wr    = 1'b0;
		o_reg_addr  = ~o_reg_addr;
		o_reg_wdata = ~o_reg_wdata;
	endtask

	// One read pulse; data taken on the falling edge after the read edge
	task automatic rd(input logic [4:0] addr, output logic [15:0] data);
		@(negedge i_clock);
		o_reg_addr = addr;
		o_reg_rd   = 1'b1;
		@(negedge i_clock);
		o_reg_rd   = 1'b0;
		o_reg_addr = ~o_reg_addr;
		data       = i_reg_rdata;
	endtask
endmodule // mgmt_station

// >>> dv/phy_vendor_config_status_tb_top.sv
// Self-checking bench for the vendor configuration and status registers
`timescale 1ns/1ps
`include "phy_vendor_cfg.svh"
module phy_vendor_config_status_tb_top;
	import phy_vendor_pkg::*;
	localparam int         STATE_MACHINE_RESET_LEN = 2;     // Shortened reset pulse
	localparam logic [4:0] STRAP     = 5'h15; // Address strap setting
	logic        i_clock, i_sys_rst, i_reg_wr, i_reg_rd, i_an_mode, i_an_done;
	logic [4:0]  i_reg_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata, rv;
	logic [3:0]  i_an_result, i_an_monitor;
	logic        enc, scr, aln, adp, flk, rpd, smr, mfp, slp, rlo, vld;
	wire  [8:0]  ctl = {enc, scr, aln, adp, flk, rpd, mfp, slp, rlo}; // Control outputs
	int          errors, num_checks, cycles;

	mgmt_station u_mgmt (.i_clock(i_clock), .i_reg_rdata(o_reg_rdata), .o_reg_addr(i_reg_addr),
		.o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata));

	phy_vendor_regs #(.STATE_MACHINE_RESET_LEN(STATE_MACHINE_RESET_LEN)) u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_strap_addr(STRAP),
		.i_an_mode(i_an_mode), .i_an_done(i_an_done), .i_an_result(i_an_result),
		.i_an_monitor(i_an_monitor), .o_encoding_bypass(enc), .o_scrambler_bypass(scr),
		.o_alignment_bypass(aln), .o_adaptation_ok_bypass(adp), .o_force_link_100(flk),
		.o_auto_reduced_power_enable(rpd), .o_state_machine_reset(smr),
		.o_preamble_suppress_control(mfp), .o_sleep(slp), .o_remote_loopout(rlo),
		.o_result_valid(vld));

	// Control outputs expected from a configuration word
	function automatic logic [8:0] cfg_ctl(input logic [15:0] w);
		return {w[15], w[14], w[13], w[12], w[7], w[4], w[2], w[1], w[0]};
	endfunction

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Count cycles of the state machine reset pulse
	task automatic pulse_len(output int n);
		n = 0;
		repeat (20) begin
			@(negedge i_clock);
			if (smr === 1'b1) n++;
		end
	endtask

	// Reset values of both words and of the control and reset outputs
	task automatic t_reset();
		repeat (5) @(negedge i_clock);
		u_mgmt.rd(`CFG_REG_ADDR, rv);
		chk(rv, 16'h0410);
		chk(ctl, 9'h008);
		chk(smr, 1'b0);
		u_mgmt.rd(`STS_REG_ADDR, rv);
		chk(rv, {4'hF, 3'b000, STRAP, 4'h0});
	endtask

	// Control bits 15..12, 7, 2 and 0 one at a time with bit 4 kept set, then reserved and read-only bits
	task automatic t_cfg();
		int          bits [7] = '{15, 14, 13, 12, 7, 2, 0};
		logic [15:0] w;
		foreach (bits[i]) begin
			w = 16'h0010 | (16'h0001 << bits[i]);
			u_mgmt.wr(`CFG_REG_ADDR, w);
			u_mgmt.rd(`CFG_REG_ADDR, rv);
			chk(rv, w | 16'h0400);
			chk(ctl, cfg_ctl(w));
		end
		u_mgmt.wr(`CFG_REG_ADDR, 16'hFBF5);
		u_mgmt.rd(`CFG_REG_ADDR, rv);
		chk(rv, 16'hF495);
		chk(ctl, cfg_ctl(16'hF495));
		u_mgmt.wr(`CFG_REG_ADDR, 16'h0000);
		u_mgmt.rd(`CFG_REG_ADDR, rv);
		chk(rv, 16'h0400);
		chk(ctl, 9'h000);
	endtask

	// State machine reset, then sleep and wake
	task automatic t_state_machine_reset();
		int n;
		u_mgmt.wr(`CFG_REG_ADDR, 16'h0018);
		pulse_len(n);
		chk(n, STATE_MACHINE_RESET_LEN);
		u_mgmt.rd(`CFG_REG_ADDR, rv);
		chk(rv, 16'h0410);
		u_mgmt.wr(`CFG_REG_ADDR, 16'h8012);
		repeat (2) @(negedge i_clock);
		chk(ctl, cfg_ctl(16'h8012));
		u_mgmt.wr(`CFG_REG_ADDR, 16'h8010);
		pulse_len(n);
		chk(n, STATE_MACHINE_RESET_LEN);
		u_mgmt.rd(`CFG_REG_ADDR, rv);
		chk(rv, 16'h8410);
		chk(ctl, cfg_ctl(16'h8410));
	endtask

	// Negotiation result, monitor codes, address write, unmapped place
	task automatic t_status();
		logic [3:0] m;
		@(negedge i_clock);
		i_an_mode   = 1'b1;
		i_an_result = 4'b0100;
		i_an_done   = 1'b1;
		@(negedge i_clock);
		i_an_done   = 1'b0;
		u_mgmt.rd(`STS_REG_ADDR, rv);
		chk(rv, {4'b0100, 3'b000, STRAP, 4'h0});
		for (int c = 0; c < 10; c++) begin
			m = c[3:0];
			i_an_monitor = m;
			u_mgmt.rd(`STS_REG_ADDR, rv);
			chk(rv[3:0], (m > 4'h8) ? 4'h0 : m);
			chk(vld, m == 4'h8);
		end
		i_an_monitor = 4'h8;
		i_an_mode    = 1'b0;
		repeat (3) @(negedge i_clock);
		chk(vld, 1'b0);
		u_mgmt.wr(`STS_REG_ADDR, 16'hFFFF);
		u_mgmt.rd(`STS_REG_ADDR, rv);
		chk(rv, 16'h41F8);
		u_mgmt.wr(5'h12, 16'hFFFF);
		u_mgmt.rd(5'h12, rv);
		chk(rv, 16'h0000);
		u_mgmt.rd(`CFG_REG_ADDR, rv);
		chk(rv, 16'h8410);
	endtask

	// Verdict and end of run
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Free-running clock
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end

	// Hang guard
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			$display("[FAIL] %0t run did not finish", $time);
			end_sim();
		end
	end

	// Main sequence
	initial begin
		errors       = 0;
		num_checks   = 0;
		cycles       = 0;
		i_sys_rst    = 1'b1;
		i_an_mode    = 1'b0;
		i_an_done    = 1'b0;
		i_an_result  = 4'h0;
		i_an_monitor = 4'h0;
		repeat (8) @(negedge i_clock);
		i_sys_rst = 1'b0;
		t_reset();
		t_cfg();
		t_state_machine_reset();
		t_status();
		end_sim();
	end
endmodule // phy_vendor_config_status_tb_top
